// File: design/alarm_match.sv
// Alarm comparison, sticky alarm flag and open-drain interrupt with AXI4-Lite registers

module alarm_match (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   clk_en,
   input  wire alarm_pkg::time_now_t   time_now,
   input  wire logic                   minute_tick,
   input  wire logic [5:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [5:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic                        irq_n_o,
   output logic                        irq_n_oe
);

   // ======================================================
   // Helpers
   function automatic logic idx_mapped(input logic [3:0] idx);
      idx_mapped = (idx == alarm_pkg::IDX_ALARM_MINUTE) || (idx == alarm_pkg::IDX_ALARM_HOUR) ||
                   (idx == alarm_pkg::IDX_ALARM_WD) || (idx == alarm_pkg::IDX_EXTENSION) ||
                   (idx == alarm_pkg::IDX_FLAG) || (idx == alarm_pkg::IDX_CONTROL);
   endfunction : idx_mapped

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      merge_byte = strb[0] ? data[7:0] : old;
   endfunction : merge_byte

   function automatic logic field_match(input logic [7:0] alarm, input logic [7:0] now,
                                        input logic [7:0] mask);
      field_match = alarm[alarm_pkg::BIT_COMPARE_DISABLE] || ((alarm & mask) == (now & mask));
   endfunction : field_match

   alarm_pkg::state_t q;
   alarm_pkg::state_t d;

   logic       wd_disabled;
   logic       wd_hit;
   logic       alarm_hit;
   logic       alarm_event;
   logic [7:0] flag_view;
   logic [3:0] rd_idx;

   // ======================================================
   // Match logic
   always_comb begin
      wd_disabled = q.alarm_wd[alarm_pkg::BIT_COMPARE_DISABLE];
      if (q.extension[alarm_pkg::BIT_TARGET_SELECT]) begin
         // Date form: bit 6 is storage, compare BCD bits 5..0
         wd_hit = wd_disabled ||
                  ((q.alarm_wd & alarm_pkg::DATE_CMP_MASK) == (time_now.date & alarm_pkg::DATE_CMP_MASK));
      end else begin
         // Any enabled weekday counts
         wd_hit = wd_disabled ||
                  (|(q.alarm_wd & time_now.weekday & alarm_pkg::WEEK_CMP_MASK));
      end
      alarm_hit = wd_hit &&
                  field_match(q.alarm_minute, time_now.minute, alarm_pkg::MIN_CMP_MASK) &&
                  field_match(q.alarm_hour, time_now.hour, alarm_pkg::HOUR_CMP_MASK);
      // Evaluated only on the minute update, so a match is one event and the
      // present time never fires on its own; all fields disabled fires each minute while control bit 0 (clock reset) is clear
      alarm_event = minute_tick && alarm_hit &&
                    !q.control[alarm_pkg::BIT_CLOCK_RESET];
      flag_view = alarm_pkg::RST_FLAG;
      flag_view[alarm_pkg::BIT_ALARM_FLAG] = q.alarm_flag;
      rd_idx = s_axi_araddr[5:2];
   end

   // ======================================================
   // Next state
   always_comb begin
      d = q;
      // Write channel capture in either order
      if (q.awready && s_axi_awvalid) begin
         d.aw_held = 1'b1;
         d.awready = 1'b0;
         d.aw_idx = s_axi_awaddr[5:2];
         d.aw_ok = idx_mapped(s_axi_awaddr[5:2]) && (s_axi_awaddr[1:0] == 2'b00);
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_held = 1'b1;
         d.wready = 1'b0;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.aw_held && q.w_held && !q.bvalid) begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = q.aw_ok ? alarm_pkg::RESP_OKAY : alarm_pkg::RESP_SLVERR;
         if (q.aw_ok) begin
            case (q.aw_idx)
               alarm_pkg::IDX_ALARM_MINUTE: d.alarm_minute = merge_byte(q.alarm_minute, q.wdata, q.wstrb);
               alarm_pkg::IDX_ALARM_HOUR:   d.alarm_hour = merge_byte(q.alarm_hour, q.wdata, q.wstrb);
               alarm_pkg::IDX_ALARM_WD:     d.alarm_wd = merge_byte(q.alarm_wd, q.wdata, q.wstrb);
               alarm_pkg::IDX_EXTENSION:    d.extension = merge_byte(q.extension, q.wdata, q.wstrb);
               alarm_pkg::IDX_CONTROL:      d.control = merge_byte(q.control, q.wdata, q.wstrb);
               alarm_pkg::IDX_FLAG: begin
                  // Only a 0 clears; a 1 leaves the flag alone
                  if (q.wstrb[0] && !q.wdata[alarm_pkg::BIT_ALARM_FLAG]) begin
                     d.alarm_flag = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
         d.awready = 1'b1;
         d.wready = 1'b1;
      end
      // Read channel: one cycle answer, held until taken
      if (q.arready && s_axi_arvalid) begin
         d.arready = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = alarm_pkg::RESP_OKAY;
         d.rdata = 32'h0000_0000;
         if (!idx_mapped(rd_idx) || (s_axi_araddr[1:0] != 2'b00)) begin
            d.rresp = alarm_pkg::RESP_SLVERR;
         end else begin
            case (rd_idx)
               alarm_pkg::IDX_ALARM_MINUTE: d.rdata[7:0] = q.alarm_minute;
               alarm_pkg::IDX_ALARM_HOUR:   d.rdata[7:0] = q.alarm_hour;
               alarm_pkg::IDX_ALARM_WD:     d.rdata[7:0] = q.alarm_wd;
               alarm_pkg::IDX_EXTENSION:    d.rdata[7:0] = q.extension;
               alarm_pkg::IDX_FLAG:         d.rdata[7:0] = flag_view;
               alarm_pkg::IDX_CONTROL:      d.rdata[7:0] = q.control;
               default:                     d.rdata[7:0] = 8'h00;
            endcase
         end
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
         d.arready = 1'b1;
      end
      // Event beats a simultaneous software clear
      if (alarm_event) begin
         d.alarm_flag = 1'b1;
      end
      // Drive low only if enabled when the flag rises; any clear of flag or
      // enable releases it, and nothing else times it out
      if (alarm_event && !q.alarm_flag && d.control[alarm_pkg::BIT_IRQ_ENABLE]) begin
         d.irq_drive = 1'b1;
      end else if (!d.alarm_flag || !d.control[alarm_pkg::BIT_IRQ_ENABLE]) begin
         d.irq_drive = 1'b0;
      end
   end

   // ======================================================
   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
         q.alarm_minute <= alarm_pkg::RST_ALARM;
         q.alarm_hour <= alarm_pkg::RST_ALARM;
         q.alarm_wd <= alarm_pkg::RST_ALARM;
         q.extension <= alarm_pkg::RST_EXTENSION;
         q.control <= alarm_pkg::RST_CONTROL;
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // ======================================================
   // Outputs from flip-flops, except irq_n_o which is tied low
   // Open drain: only ever drives low, other sources wire-AND outside
   assign irq_n_o = 1'b0;
   assign irq_n_oe = q.irq_drive;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

endmodule : alarm_match

// File: design/alarm_pkg.sv
// Package: register map, field positions and carriers of the alarm match block
package alarm_pkg;

   // ======================================================
   // Register indices (printed offsets, byte address = 4 x index)
   localparam logic [3:0] IDX_ALARM_MINUTE = 4'h8;
   localparam logic [3:0] IDX_ALARM_HOUR   = 4'h9;
   localparam logic [3:0] IDX_ALARM_WD     = 4'hA;
   localparam logic [3:0] IDX_EXTENSION    = 4'hD;
   localparam logic [3:0] IDX_FLAG         = 4'hE;
   localparam logic [3:0] IDX_CONTROL      = 4'hF;

   // ======================================================
   // Field positions
   localparam int BIT_COMPARE_DISABLE = 7;
   localparam int BIT_TARGET_SELECT   = 6;
   localparam int BIT_ALARM_FLAG      = 3;
   localparam int BIT_IRQ_ENABLE      = 3;
   localparam int BIT_CLOCK_RESET     = 0;

   // Bit 6 of the hour alarm is a plain storage bit
   localparam logic [7:0] HOUR_CMP_MASK = 8'h3F;
   localparam logic [7:0] DATE_CMP_MASK = 8'h3F;
   localparam logic [7:0] WEEK_CMP_MASK = 8'h7F;
   localparam logic [7:0] MIN_CMP_MASK  = 8'h7F;

   // ======================================================
   // Reset values
   localparam logic [7:0] RST_ALARM     = 8'h00;
   localparam logic [7:0] RST_EXTENSION = 8'h00;
   localparam logic [7:0] RST_FLAG      = 8'h00;
   localparam logic [7:0] RST_CONTROL   = 8'h00;

   // AXI answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Running time from the counters: BCD minute, hour, date, one-hot weekday
   typedef struct packed {
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] date;
      logic [7:0] weekday;
   } time_now_t;

   typedef struct packed {
      logic [7:0] alarm_minute;
      logic [7:0] alarm_hour;
      logic [7:0] alarm_wd;
      logic [7:0] extension;
      logic       alarm_flag;
      logic [7:0] control;
      logic       irq_drive;
      logic       awready;
      logic       wready;
      logic       aw_held;
      logic       w_held;
      logic [3:0] aw_idx;
      logic       aw_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

endpackage : alarm_pkg

// File: tb/irq_host.sv
// Host side model: pull-up on the shared interrupt line
module irq_host (
   input  wire logic irq_n_o,
   input  wire logic irq_n_oe,
   output logic      irq_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // A released pin floats to the pull-up, never to the last driven value
   assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
endmodule : irq_host

// File: tb/alarm_match_asserts.sv
// Checker: bus handshake and interrupt pin timing of the alarm block
module alarm_match_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic minute_tick,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_n_o,
   input wire logic irq_n_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_pin_open_drain: assert property (irq_n_o == 1'b0)
      else $error("interrupt data not low");
   a_irq_rise_tick: assert property ($rose(irq_n_oe) |-> $past(minute_tick))
      else $error("interrupt rose without minute tick");
   a_irq_fall_write: assert property ($fell(irq_n_oe) |-> $rose(s_axi_bvalid))
      else $error("interrupt released without register write");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer dropped");
endmodule : alarm_match_asserts

bind alarm_match alarm_match_asserts i_chk (.*);

// File: tb/rtc_alarm_match_interrupt_bench.sv
// Bench: alarm match, sticky flag and interrupt through the register bus
module rtc_alarm_match_interrupt_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, sys_rst = 1, clk_en = 1, minute_tick = 0, irq_n_o, irq_n_oe, irq_line;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   alarm_pkg::time_now_t time_now = '0;
   int cyc = 0, error_cnt = 0, n_tests = 0;
   alarm_match i_dut (.*);
   irq_host i_host (.*);
   always #50 clk = ~clk;
   // ======================================================
   // Bus and check tasks
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", exp, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : rd
   task automatic tk(input logic [31:0] t);
      @(posedge clk);
      time_now <= t;
      minute_tick <= 1'b1;
      @(posedge clk);
      minute_tick <= 1'b0;
      @(negedge clk);
   endtask : tk
   task automatic fl(input logic f, input logic pin);
      rd(alarm_pkg::IDX_FLAG, 32'(f) << alarm_pkg::BIT_ALARM_FLAG);
      chk("irq_line", {31'h0, pin}, {31'h0, irq_line});
   endtask : fl
   // ======================================================
   // Scenarios
   task automatic s_store;
      rd(alarm_pkg::IDX_ALARM_HOUR, {24'h0, alarm_pkg::RST_ALARM});
      rd(alarm_pkg::IDX_CONTROL, {24'h0, alarm_pkg::RST_CONTROL});
      wr(alarm_pkg::IDX_ALARM_MINUTE, 8'h5A);
      wr(alarm_pkg::IDX_ALARM_HOUR, 8'h40);
      rd(alarm_pkg::IDX_ALARM_MINUTE, 32'h0000_005A);
      rd(alarm_pkg::IDX_ALARM_HOUR, 32'h0000_0040);
      wr(4'h3, 8'hFF, alarm_pkg::RESP_SLVERR);
      rd(4'h3, 32'h0000_0000, alarm_pkg::RESP_SLVERR);
   endtask : s_store
   task automatic s_week;
      wr(alarm_pkg::IDX_EXTENSION, 8'h00);
      wr(alarm_pkg::IDX_CONTROL, 8'h08);
      wr(alarm_pkg::IDX_ALARM_MINUTE, 8'h30);
      wr(alarm_pkg::IDX_ALARM_HOUR, 8'h07);
      wr(alarm_pkg::IDX_ALARM_WD, 8'h2A);
      tk(32'h3007_2A04);
      fl(1'b0, 1'b1);
      tk(32'h3007_0108);
      fl(1'b1, 1'b0);
      wr(alarm_pkg::IDX_FLAG, 8'h08);
      fl(1'b1, 1'b0);
      wr(alarm_pkg::IDX_FLAG, 8'h00);
      fl(1'b0, 1'b1);
   endtask : s_week
   task automatic s_date;
      wr(alarm_pkg::IDX_EXTENSION, 8'h40);
      wr(alarm_pkg::IDX_ALARM_WD, 8'h15);
      wr(alarm_pkg::IDX_ALARM_HOUR, 8'h47);
      tk(32'h3007_1600);
      fl(1'b0, 1'b1);
      tk(32'h3007_1500);
      fl(1'b1, 1'b0);
      wr(alarm_pkg::IDX_FLAG, 8'h00);
   endtask : s_date
   task automatic s_every;
      wr(alarm_pkg::IDX_ALARM_MINUTE, 8'h80);
      wr(alarm_pkg::IDX_ALARM_HOUR, 8'h80);
      wr(alarm_pkg::IDX_ALARM_WD, 8'h80);
      wr(alarm_pkg::IDX_CONTROL, 8'h09);
      tk(32'h1122_3344);
      fl(1'b0, 1'b1);
      wr(alarm_pkg::IDX_CONTROL, 8'h00);
      repeat (5) @(posedge clk);
      fl(1'b0, 1'b1);
      tk(32'h1223_0101);
      fl(1'b1, 1'b1);
      wr(alarm_pkg::IDX_FLAG, 8'h00);
      wr(alarm_pkg::IDX_CONTROL, 8'h08);
      tk(32'h1323_0101);
      repeat (20) @(posedge clk);
      fl(1'b1, 1'b0);
      wr(alarm_pkg::IDX_CONTROL, 8'h00);
      fl(1'b1, 1'b1);
   endtask : s_every
   // Clock enable low must swallow a tick that would otherwise fire
   task automatic s_freeze;
      wr(alarm_pkg::IDX_FLAG, 8'h00);
      wr(alarm_pkg::IDX_CONTROL, 8'h08);
      @(posedge clk);
      clk_en <= 1'b0;
      tk(32'h1424_0101);
      @(posedge clk);
      clk_en <= 1'b1;
      fl(1'b0, 1'b1);
      tk(32'h1524_0101);
      fl(1'b1, 1'b0);
      wr(alarm_pkg::IDX_FLAG, 8'h00);
      fl(1'b0, 1'b1);
   endtask : s_freeze
   // ======================================================
   // Main sequence and hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      s_store();
      s_week();
      s_date();
      s_every();
      s_freeze();
      summarize();
   end
endmodule : rtc_alarm_match_interrupt_bench
